// [rtl/tch_host.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tch_map.svh"
module tch_host
	import tch_pkg::*;
#(
	parameter int QTR_CYC      = `TCH_QTR_CYC,
	parameter int RST_LOW_CYC  = `TCH_RST_LOW_CYC,
	parameter int INT_HOLD_CYC = `TCH_INT_HOLD_CYC,
	parameter int BOOT_CYC     = `TCH_BOOT_CYC,
	parameter int FIFO_DEPTH   = `TCH_FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// Link
	tch_i2c_if.host          bus,
	// Address strap choice
	input  wire logic        i_addr_alt,
	// Request queue
	input  wire logic        i_req_valid,
	output logic             o_req_ready,
	input  wire logic        i_req_rnw,
	input  wire logic [2:0]  i_req_len,
	input  wire logic [15:0] i_req_reg,
	input  wire logic [7:0]  i_req_data,
	// Results
	output logic             o_rd_valid,
	output logic [7:0]       o_rd_data,
	output logic             o_done,
	output logic             o_nack,
	output logic             o_boot_done,
	output logic             o_int_req
);
	tch_host_st_e st_q;
	tch_req_s     req_q;
	tch_req_s     in_w;
	tch_req_s     head_w;
	logic         head_valid;
	logic         pop;
	logic [1:0]   s1_q;
	logic [1:0]   s2_q;
	logic [15:0]  q_cnt_q;
	logic [1:0]   qph_q;
	logic         tick;
	logic [1:0]   boot_ph_q;
	logic [15:0]  boot_cnt_q;
	logic         alt_q;
	logic [2:0]   idx_q;
	logic [3:0]   bit_q;
	logic [7:0]   sh_q;
	logic [2:0]   left_q;
	logic         rx_q;
	logic         scl_oe_q;
	logic         sda_oe_q;
	logic         rst_n_q;
	logic         int_oe_q;

	// Byte sent at each position of the transfer
	function automatic logic [7:0] tx_byte(input tch_req_s r, input logic [2:0] i,
		input logic alt);
		logic [6:0] a;
		a = alt ? `TCH_ADDR_ALT : `TCH_ADDR_PRI;
		unique case (i)
			3'd0:    return {a, 1'b0};
			3'd1:    return r.reg_addr[15:8];
			3'd2:    return r.reg_addr[7:0];
			default: return r.rnw ? {a, 1'b1} : r.data;
		endcase
	endfunction : tx_byte

	assign in_w = '{rnw: i_req_rnw, len: i_req_len, reg_addr: i_req_reg, data: i_req_data};
	assign pop  = head_valid & (st_q == TH_IDLE);
	assign tick = (q_cnt_q == 16'(QTR_CYC - 1));

	// Queue stalls the user only when all FIFO_DEPTH entries are full; it keeps accepting while a transfer runs
	tch_fifo #(.W($bits(tch_req_s)), .D(FIFO_DEPTH)) i_tch_fifo (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_valid (i_req_valid),
		.o_ready (o_req_ready),
		.i_data  (in_w),
		.o_valid (head_valid),
		.i_ready (pop),
		.o_data  (head_w)
	);

	// Sync of {int_n, sda}
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s1_q <= 2'b11;
			s2_q <= 2'b11;
		end else begin
			s1_q <= {bus.int_n, bus.sda};
			s2_q <= s1_q;
		end
	end

	// Quarter-bit timebase, realigned at each new transfer
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			q_cnt_q <= 16'h0000;
			qph_q   <= 2'd0;
		end else if (pop || tick) begin
			q_cnt_q <= 16'h0000;
			qph_q   <= pop ? 2'd0 : qph_q + 2'd1;
		end else begin
			q_cnt_q <= q_cnt_q + 16'd1;
		end
	end

	// Power-on strap: reset low, int held at the chosen level past release
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			boot_ph_q  <= 2'd0;
			boot_cnt_q <= 16'h0000;
			alt_q      <= 1'b0;
			rst_n_q    <= 1'b0;
			int_oe_q   <= 1'b0;
		end else if (boot_ph_q != 2'd3) begin
			boot_cnt_q <= boot_cnt_q + 16'd1;
			unique case (boot_ph_q)
				2'd0: begin
					alt_q    <= i_addr_alt;
					int_oe_q <= 1'b1;
					if (boot_cnt_q == 16'(RST_LOW_CYC - 1)) begin
						rst_n_q    <= 1'b1;
						boot_cnt_q <= 16'h0000;
						boot_ph_q  <= 2'd1;
					end
				end
				2'd1: begin
					if (boot_cnt_q == 16'(INT_HOLD_CYC - 1)) begin
						int_oe_q   <= 1'b0;
						boot_cnt_q <= 16'h0000;
						boot_ph_q  <= 2'd2;
					end
				end
				default: begin
					if (boot_cnt_q == 16'(BOOT_CYC - 1)) begin
						boot_ph_q <= 2'd3;
					end
				end
			endcase
		end
	end

	// Transfer sequencer; SDA moves in quarter 0 (SCL low) except start/stop
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_q       <= TH_BOOT;
			req_q      <= '0;
			idx_q      <= 3'd0;
			bit_q      <= 4'h0;
			sh_q       <= 8'h00;
			left_q     <= 3'd0;
			rx_q       <= 1'b0;
			scl_oe_q   <= 1'b0;
			sda_oe_q   <= 1'b0;
			o_rd_valid <= 1'b0;
			o_rd_data  <= 8'h00;
			o_done     <= 1'b0;
			o_nack     <= 1'b0;
		end else begin
			o_rd_valid <= 1'b0;
			o_done     <= 1'b0;
			unique case (st_q)
				TH_BOOT: begin
					if (boot_ph_q == 2'd3) begin
						st_q <= TH_IDLE;
					end
				end
				TH_IDLE: begin
					if (pop) begin
						req_q  <= head_w;
						idx_q  <= 3'd0;
						rx_q   <= 1'b0;
						left_q <= head_w.len;
						o_nack <= 1'b0;
						st_q   <= TH_START;
					end
				end
				TH_START: begin
					if (tick) begin
						unique case (qph_q)
							2'd0: begin
								scl_oe_q <= 1'b1;
								sda_oe_q <= 1'b0;
							end
							2'd1: scl_oe_q <= 1'b0;
							2'd2: sda_oe_q <= 1'b1;
							2'd3: begin
								scl_oe_q <= 1'b1;
								bit_q    <= 4'h0;
								sh_q     <= tx_byte(req_q, idx_q, alt_q);
								st_q     <= TH_BIT;
							end
						endcase
					end
				end
				TH_BIT: begin
					if (tick) begin
						unique case (qph_q)
							2'd0: begin
								if (bit_q != 4'd8) begin
									sda_oe_q <= ~rx_q & ~sh_q[7];
								end else begin
									sda_oe_q <= rx_q & (left_q != 3'd0);
								end
							end
							2'd1: scl_oe_q <= 1'b0;
							2'd2: begin
								if (rx_q && bit_q != 4'd8) begin
									sh_q <= {sh_q[6:0], s2_q[0]};
								end else if (bit_q == 4'd8 && !rx_q) begin
									o_nack <= s2_q[0];
								end
							end
							2'd3: begin
								scl_oe_q <= 1'b1;
								bit_q    <= bit_q + 4'd1;
								if (bit_q != 4'd8) begin
									if (!rx_q) begin
										sh_q <= {sh_q[6:0], 1'b0};
									end
								end else if (rx_q) begin
									o_rd_valid <= 1'b1;
									o_rd_data  <= sh_q;
									bit_q      <= 4'h0;
									left_q     <= left_q - 3'd1;
									if (left_q == 3'd0) begin
										st_q <= TH_STOP;
									end
								end else if (o_nack) begin
									st_q <= TH_STOP;
								end else if (idx_q == 3'd3) begin
									bit_q <= 4'h0;
									rx_q  <= req_q.rnw;
									if (!req_q.rnw) begin
										st_q <= TH_STOP;
									end
								end else if (idx_q == 3'd2 && req_q.rnw) begin
									idx_q <= 3'd3;
									st_q  <= TH_START;
								end else begin
									bit_q <= 4'h0;
									idx_q <= idx_q + 3'd1;
									sh_q  <= tx_byte(req_q, idx_q + 3'd1, alt_q);
								end
							end
						endcase
					end
				end
				TH_STOP: begin
					if (tick) begin
						unique case (qph_q)
							2'd0: sda_oe_q <= 1'b1;
							2'd1: scl_oe_q <= 1'b0;
							2'd2: sda_oe_q <= 1'b0;
							2'd3: begin
								o_done <= 1'b1;
								st_q   <= TH_IDLE;
							end
						endcase
					end
				end
				default: begin
					st_q     <= TH_IDLE;
					scl_oe_q <= 1'b0;
					sda_oe_q <= 1'b0;
				end
			endcase
		end
	end

	// Status toward the user
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_boot_done <= 1'b0;
			o_int_req   <= 1'b0;
		end else begin
			o_boot_done <= (boot_ph_q == 2'd3);
			o_int_req   <= (boot_ph_q == 2'd3) & ~s2_q[1];
		end
	end

	// SCL and SDA are open drain; int is driven to a level only while strapping
	assign bus.scl_h_o  = 1'b0;
	assign bus.scl_h_oe = scl_oe_q;
	assign bus.sda_h_o  = 1'b0;
	assign bus.sda_h_oe = sda_oe_q;
	assign bus.int_h_o  = alt_q;
	assign bus.int_h_oe = int_oe_q;
	assign bus.rst_n    = rst_n_q;
endmodule : tch_host
`default_nettype wire

// [rtl/tch_map.svh]
`ifndef TCH_MAP_SVH
`define TCH_MAP_SVH
// 7-bit slave addresses; the byte on the wire adds the direction bit
`define TCH_ADDR_PRI     7'h5d
`define TCH_ADDR_ALT     7'h14
// Register space held by the device end
`define TCH_REG_BASE     16'h8140
`define TCH_REG_DEPTH    32
`define TCH_STATUS_REG   16'h814e
`define TCH_STATUS_RDY   7
// Timing
`define TCH_CLK_HZ       40000000
`define TCH_SCL_MAX_HZ   400000
`define TCH_QTR_CYC      ((`TCH_CLK_HZ + 4 * `TCH_SCL_MAX_HZ - 1) / (4 * `TCH_SCL_MAX_HZ))
`define TCH_CYC_PER_US   (`TCH_CLK_HZ / 1000000)
`define TCH_RST_LOW_US   100
`define TCH_INT_HOLD_US  50
`define TCH_BOOT_US      100
`define TCH_RST_LOW_CYC  (`TCH_RST_LOW_US * `TCH_CYC_PER_US)
`define TCH_INT_HOLD_CYC (`TCH_INT_HOLD_US * `TCH_CYC_PER_US)
`define TCH_BOOT_CYC     (`TCH_BOOT_US * `TCH_CYC_PER_US)
`define TCH_FIFO_DEPTH   8
`endif

// [rtl/tch_pkg.sv]
package tch_pkg;
	// Device end link states
	typedef enum logic [4:0] {
		TD_IDLE = 5'b00001,
		TD_RX   = 5'b00010,
		TD_ACK  = 5'b00100,
		TD_TX   = 5'b01000,
		TD_TACK = 5'b10000
	} tch_dev_st_e;
	// Host end sequencer states
	typedef enum logic [4:0] {
		TH_BOOT  = 5'b00001,
		TH_IDLE  = 5'b00010,
		TH_START = 5'b00100,
		TH_BIT   = 5'b01000,
		TH_STOP  = 5'b10000
	} tch_host_st_e;
	// One queued host request
	typedef struct packed {
		logic        rnw;
		logic [2:0]  len;
		logic [15:0] reg_addr;
		logic [7:0]  data;
	} tch_req_s;
endpackage : tch_pkg

// [rtl/tch_i2c_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface tch_i2c_if;
	// Drivers of each party
	logic scl_h_o;
	logic scl_h_oe;
	logic sda_h_o;
	logic sda_h_oe;
	logic sda_d_o;
	logic sda_d_oe;
	logic int_h_o;
	logic int_h_oe;
	logic int_d_o;
	logic int_d_oe;
	logic rst_n;
	// Resolved wire levels, pull-ups modelled as the default
	logic scl;
	logic sda;
	logic int_n;
	assign scl   = scl_h_oe ? scl_h_o : 1'b1;
	assign sda   = (sda_h_oe ? sda_h_o : 1'b1) & (sda_d_oe ? sda_d_o : 1'b1);
	assign int_n = int_h_oe ? int_h_o : (int_d_oe ? int_d_o : 1'b1);
	modport dev  (input scl, sda, int_n, rst_n,
		output sda_d_o, sda_d_oe, int_d_o, int_d_oe);
	modport host (input scl, sda, int_n,
		output scl_h_o, scl_h_oe, sda_h_o, sda_h_oe, int_h_o, int_h_oe, rst_n);
endinterface : tch_i2c_if
`default_nettype wire

// [rtl/tch_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module tch_fifo #(
	parameter int W = 28,
	parameter int D = 8
) (
	// Clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	// Fill side
	input  wire logic         i_valid,
	output logic              o_ready,
	input  wire logic [W-1:0] i_data,
	// Drain side
	output logic              o_valid,
	input  wire logic         i_ready,
	output logic [W-1:0]      o_data
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;
	logic [W-1:0]  mem_q [D];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0]   cnt_q;
	logic [AW:0]   cnt_d;
	logic          full_q;
	logic          empty_q;
	logic          push;
	logic          pop;

	function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] p);
		return (p == AW'(D - 1)) ? '0 : p + AW'(1);
	endfunction : ptr_next

	// Flags are registered so the ready seen upstream is a flop
	assign push    = i_valid & ~full_q;
	assign pop     = i_ready & ~empty_q;
	assign o_ready = ~full_q;
	assign o_valid = ~empty_q;
	assign o_data  = mem_q[rp_q];
	assign cnt_d   = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

	// Storage, no reset needed on data words
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_q[wp_q] <= i_data;
		end
	end

	// Pointers and occupancy
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			wp_q    <= '0;
			rp_q    <= '0;
			cnt_q   <= '0;
			full_q  <= 1'b0;
			empty_q <= 1'b1;
		end else begin
			if (push) begin
				wp_q <= ptr_next(wp_q);
			end
			if (pop) begin
				rp_q <= ptr_next(rp_q);
			end
			cnt_q   <= cnt_d;
			full_q  <= (cnt_d == (AW+1)'(D));
			empty_q <= (cnt_d == '0);
		end
	end
endmodule : tch_fifo
`default_nettype wire

// [rtl/tch_dev.sv]
// Functional notes
// - Answer write/read pair BA/BB or 28/29
// - Address pair strapped by int at reset release
// - Only host starts transfers; device never initiates
// - SDA falling while SCL high is start
// - SDA rising while SCL high is stop
// - SDA changes only while SCL is low
// - Matching address acked low on ninth clock
// - Mismatch: no ack, idle until next start
// - Byte is eight bits plus ack slot
// - Address LSB zero writes, one reads
// - Write: address, register high, low, data
// - Pointer increments after each written byte
// - Host stops after last acked write byte
// - Read: set pointer, repeated start, read address
// - Reads stream consecutive bytes; host acks all but last
// - Host ends read with nack then stop
// - SCL no faster than 400 kbit/s
// - Interrupt pulled low to request a transaction
// - Ready flag bit 7 of 814E, host clears
`timescale 1ns/1ps
`default_nettype none
`include "tch_map.svh"
module tch_dev
	import tch_pkg::*;
#(
	parameter int          REG_DEPTH = `TCH_REG_DEPTH,
	parameter logic [15:0] REG_BASE  = `TCH_REG_BASE
) (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// Link
	tch_i2c_if.dev           bus,
	// Local register update
	input  wire logic        i_loc_we,
	input  wire logic [15:0] i_loc_addr,
	input  wire logic [7:0]  i_loc_data,
	input  wire logic        i_touch_ready,
	// Host write notification and status
	output logic             o_wr_valid,
	output logic [15:0]      o_wr_addr,
	output logic [7:0]       o_wr_data,
	output logic             o_coord_ready,
	output logic             o_addr_alt,
	output logic             o_busy
);
	localparam int IW = (REG_DEPTH > 1) ? $clog2(REG_DEPTH) : 1;

	logic [3:0]  s1_q;
	logic [3:0]  s2_q;
	logic [3:0]  s3_q;
	logic        scl;
	logic        sda;
	logic        scl_p;
	logic        sda_p;
	logic        pin_rst_n;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_c;
	logic        stop_c;
	logic        pin_rel;
	tch_dev_st_e st_q;
	logic [3:0]  cnt_q;
	logic [7:0]  sh_q;
	logic [1:0]  phase_q;
	logic        rnw_q;
	logic        ackd_q;
	logic [15:0] ptr_q;
	logic        sda_oe_q;
	logic        int_oe_q;
	logic        alt_q;
	logic        flag_q;
	logic [7:0]  mem_q [REG_DEPTH];
	logic [7:0]  cur_byte;
	logic [6:0]  own_addr;
	logic        wr_evt;

	function automatic logic reg_hit(input logic [15:0] a);
		logic [15:0] off;
		off = a - REG_BASE;
		return off < 16'(REG_DEPTH);
	endfunction : reg_hit

	function automatic logic [IW-1:0] reg_idx(input logic [15:0] a);
		logic [15:0] off;
		off = a - REG_BASE;
		return off[IW-1:0];
	endfunction : reg_idx

	// Two-stage sync of {rst_n, int_n, scl, sda}; third stage only for edges
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s1_q <= 4'hf;
			s2_q <= 4'hf;
			s3_q <= 4'hf;
		end else begin
			s1_q <= {bus.rst_n, bus.int_n, bus.scl, bus.sda};
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Line events; scl and sda share one sync depth so their order is kept
	assign pin_rst_n = s2_q[3];
	assign scl       = s2_q[1];
	assign sda       = s2_q[0];
	assign scl_p     = s3_q[1];
	assign sda_p     = s3_q[0];
	assign scl_rise  = scl & ~scl_p;
	assign scl_fall  = ~scl & scl_p;
	assign start_c   = scl & scl_p & sda_p & ~sda;
	assign stop_c    = scl & scl_p & ~sda_p & sda;
	assign pin_rel   = pin_rst_n & ~s3_q[3];
	assign own_addr  = alt_q ? `TCH_ADDR_ALT : `TCH_ADDR_PRI;
	assign wr_evt    = pin_rst_n & (st_q == TD_RX) & scl_fall
		& (cnt_q == 4'd8) & (phase_q == 2'd3);

	// Strap caught at the release of the reset pin, not under reset
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			alt_q <= 1'b0;
		end else if (pin_rel) begin
			alt_q <= s2_q[2];
		end
	end

	// Byte presented to a read, status flag overlaid on bit 7
	always_comb begin
		cur_byte = 8'h00;
		if (reg_hit(ptr_q)) begin
			cur_byte = mem_q[reg_idx(ptr_q)];
		end
		if (ptr_q == `TCH_STATUS_REG) begin
			cur_byte[`TCH_STATUS_RDY] = flag_q;
		end
	end

	// Link state machine; drive changes follow a detected SCL fall, except the release on start, stop or pin reset
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_q     <= TD_IDLE;
			cnt_q    <= 4'h0;
			sh_q     <= 8'h00;
			phase_q  <= 2'd0;
			rnw_q    <= 1'b0;
			ackd_q   <= 1'b0;
			ptr_q    <= 16'h0000;
			sda_oe_q <= 1'b0;
		end else if (!pin_rst_n) begin
			st_q     <= TD_IDLE;
			sda_oe_q <= 1'b0;
		end else if (stop_c) begin
			st_q     <= TD_IDLE;
			sda_oe_q <= 1'b0;
		end else if (start_c) begin
			st_q     <= TD_RX;
			phase_q  <= 2'd0;
			cnt_q    <= 4'h0;
			sda_oe_q <= 1'b0;
		end else begin
			unique case (st_q)
				TD_IDLE: begin
				end
				TD_RX: begin
					if (scl_rise) begin
						sh_q  <= {sh_q[6:0], sda};
						cnt_q <= cnt_q + 4'd1;
					end else if (scl_fall && cnt_q == 4'd8) begin
						sda_oe_q <= 1'b1;
						st_q     <= TD_ACK;
						unique case (phase_q)
							2'd0: begin
								rnw_q <= sh_q[0];
								if (sh_q[7:1] != own_addr) begin
									sda_oe_q <= 1'b0;
									st_q     <= TD_IDLE;
								end
							end
							2'd1: ptr_q[15:8] <= sh_q;
							2'd2: ptr_q[7:0] <= sh_q;
							2'd3: ptr_q <= ptr_q + 16'd1;
						endcase
					end
				end
				TD_ACK: begin
					if (scl_fall) begin
						cnt_q <= 4'h0;
						if (phase_q == 2'd0 && rnw_q) begin
							sh_q     <= cur_byte;
							sda_oe_q <= ~cur_byte[7];
							st_q     <= TD_TX;
						end else begin
							sda_oe_q <= 1'b0;
							st_q     <= TD_RX;
							if (phase_q != 2'd3) begin
								phase_q <= phase_q + 2'd1;
							end
						end
					end
				end
				TD_TX: begin
					if (scl_rise) begin
						cnt_q <= cnt_q + 4'd1;
					end else if (scl_fall) begin
						if (cnt_q == 4'd8) begin
							sda_oe_q <= 1'b0;
							ptr_q    <= ptr_q + 16'd1;
							st_q     <= TD_TACK;
						end else begin
							sh_q     <= {sh_q[6:0], 1'b0};
							sda_oe_q <= ~sh_q[6];
						end
					end
				end
				TD_TACK: begin
					if (scl_rise) begin
						ackd_q <= ~sda;
					end else if (scl_fall) begin
						cnt_q <= 4'h0;
						if (ackd_q) begin
							sh_q     <= cur_byte;
							sda_oe_q <= ~cur_byte[7];
							st_q     <= TD_TX;
						end else begin
							st_q <= TD_IDLE;
						end
					end
				end
				default: begin
					st_q     <= TD_IDLE;
					sda_oe_q <= 1'b0;
				end
			endcase
		end
	end

	// Register storage; a local write beats a host write to the same byte
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			for (int i = 0; i < REG_DEPTH; i++) begin
				mem_q[i] <= 8'h00;
			end
		end else begin
			if (wr_evt && reg_hit(ptr_q)) begin
				mem_q[reg_idx(ptr_q)] <= sh_q;
			end
			if (i_loc_we && reg_hit(i_loc_addr)) begin
				mem_q[reg_idx(i_loc_addr)] <= i_loc_data;
			end
		end
	end

	// Ready flag: new touch data sets it even in the cycle the host clears it
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			flag_q <= 1'b0;
		end else if (!pin_rst_n) begin
			flag_q <= 1'b0;
		end else begin
			if (wr_evt && ptr_q == `TCH_STATUS_REG) begin
				flag_q <= sh_q[`TCH_STATUS_RDY];
			end
			if (i_touch_ready) begin
				flag_q <= 1'b1;
			end
		end
	end

	// Interrupt held low while data waits; released under pin reset for strapping
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			int_oe_q <= 1'b0;
		end else begin
			int_oe_q <= flag_q & pin_rst_n;
		end
	end

	// User-side outputs
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_wr_valid <= 1'b0;
			o_wr_addr  <= 16'h0000;
			o_wr_data  <= 8'h00;
			o_busy     <= 1'b0;
		end else begin
			o_wr_valid <= wr_evt;
			if (wr_evt) begin
				o_wr_addr <= ptr_q;
				o_wr_data <= sh_q;
			end
			o_busy <= (st_q != TD_IDLE);
		end
	end

	// Open-drain pins only ever pull low
	assign bus.sda_d_o    = 1'b0;
	assign bus.sda_d_oe   = sda_oe_q;
	assign bus.int_d_o    = 1'b0;
	assign bus.int_d_oe   = int_oe_q;
	assign o_coord_ready  = flag_q;
	assign o_addr_alt     = alt_q;
endmodule : tch_dev
`default_nettype wire

// [dv/tch_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module tch_properties (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst,
	// Resolved link wires and party enables
	input  wire logic scl,
	input  wire logic sda,
	input  wire logic sda_d_oe,
	input  wire logic int_d_oe,
	input  wire logic int_h_oe,
	input  wire logic rst_n
);
	logic       scl_q;
	logic       sda_q;
	logic       fb_q;
	logic       rd_q;
	logic [3:0] k_q;
	wire        st   = scl && scl_q && sda_q && !sda;
	wire        rise = scl && !scl_q;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	// Wire history, idle high like the pull-ups
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
		end
	end

	// Clock count within a byte; a start restarts it, first byte decides direction
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			k_q  <= 4'h0;
			fb_q <= 1'b0;
			rd_q <= 1'b0;
		end else if (st) begin
			k_q  <= 4'h0;
			fb_q <= 1'b1;
			rd_q <= 1'b0;
		end else if (rise) begin
			k_q <= (k_q == 4'h8) ? 4'h0 : k_q + 4'h1;
			if (k_q == 4'h8)
				fb_q <= 1'b0;
			if (fb_q && k_q == 4'h7)
				rd_q <= sda;
		end
	end

	sequence s_start;
		st;
	endsequence
	sequence s_stop;
		scl && scl_q && !sda_q && sda;
	endsequence

	chk_dev_sda_edge: assert property ($changed(sda_d_oe) |-> !scl && !$past(scl))
		else $error("device moved data while clock high");
	chk_dev_quiet_rst: assert property ((!rst_n && !$past(rst_n)) |-> !sda_d_oe && !int_d_oe)
		else $error("device drives while held in pin reset");
	chk_start_free: assert property (s_start |-> !sda_d_oe)
		else $error("device holds data at start");
	chk_stop_idle: assert property (s_stop |=> !sda_d_oe [*8])
		else $error("device drives after stop");
	chk_ack_ninth: assert property ((rise && k_q == 4'h8 && (fb_q || !rd_q)) |-> sda_d_oe && !sda)
		else $error("no acknowledge on ninth clock");
	chk_wr_bits_free: assert property ((rise && k_q != 4'h8 && (fb_q || !rd_q)) |-> !sda_d_oe)
		else $error("device drives during host data bits");
	chk_rd_ack_free: assert property ((rise && k_q == 4'h8 && !fb_q && rd_q) |-> !sda_d_oe)
		else $error("device holds line in host acknowledge slot");
	chk_strap_hold: assert property ($rose(rst_n) |-> int_h_oe [*8])
		else $error("strap level dropped at reset release");
endmodule : tch_properties
`default_nettype wire

// [dv/touch_ctrl_i2c_register_port_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module touch_ctrl_i2c_register_port_tb;
	logic        i_clk, i_rst, addr_alt, rq_v, rq_rnw, loc_we, touch, scl_q;
	logic [2:0]  rq_len;
	logic [15:0] rq_reg, loc_addr, wr_addr;
	logic [7:0]  rq_data, loc_data, wr_data, rd_data, re, mem [bit [15:0]];
	logic        rq_rdy, rd_v, done, nack, boot_done, int_req, wr_v, coord, alt_o, busy;
	logic [23:0] wr_q [$], we;
	logic [7:0]  rd_q [$];
	int          err_total, n_tests, issued, done_n, gap;

	tch_i2c_if bus ();
	tch_host #(.RST_LOW_CYC(20), .INT_HOLD_CYC(20), .BOOT_CYC(20)) i_tch_host (.i_clk, .i_rst,
		.bus(bus), .i_addr_alt(addr_alt), .i_req_valid(rq_v), .o_req_ready(rq_rdy),
		.i_req_rnw(rq_rnw), .i_req_len(rq_len), .i_req_reg(rq_reg), .i_req_data(rq_data),
		.o_rd_valid(rd_v), .o_rd_data(rd_data), .o_done(done), .o_nack(nack),
		.o_boot_done(boot_done), .o_int_req(int_req));
	tch_dev i_tch_dev (.i_clk, .i_rst, .bus(bus), .i_loc_we(loc_we), .i_loc_addr(loc_addr),
		.i_loc_data(loc_data), .i_touch_ready(touch), .o_wr_valid(wr_v), .o_wr_addr(wr_addr),
		.o_wr_data(wr_data), .o_coord_ready(coord), .o_addr_alt(alt_o), .o_busy(busy));
	tch_properties i_tch_properties (.i_clk, .i_rst, .scl(bus.scl), .sda(bus.sda),
		.sda_d_oe(bus.sda_d_oe), .int_d_oe(bus.int_d_oe), .int_h_oe(bus.int_h_oe),
		.rst_n(bus.rst_n));

	// 40 MHz system clock
	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end

	task automatic report_and_stop();
		if (err_total == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : report_and_stop

	// Queue one request and note what the far end must show for it
	task automatic push(input logic rnw, input logic [2:0] len, input logic [15:0] a,
		input logic [7:0] d);
		rq_v = 1'b1;
		rq_rnw = rnw;
		rq_len = len;
		rq_reg = a;
		rq_data = d;
		for (int i = 0; rnw && i <= len; i++)
			rd_q.push_back(mem.exists(a + 16'(i)) ? mem[a + 16'(i)] : 8'h00);
		if (!rnw) begin
			wr_q.push_back({a, d});
			mem[a] = d;
		end
		issued++;
		@(posedge i_clk);
		#1;
	endtask : push

	// Valid drops, then wait for every queued transfer to finish
	task automatic settle();
		rq_v = 1'b0;
		for (int i = 0; i < 40000 && done_n < issued; i++)
			@(posedge i_clk);
		// A transfer that never finished counts against the run
		if (done_n < issued)
			err_total++;
		@(posedge i_clk);
		#1;
	endtask : settle

	// Monitor: results against the oldest note, clock pacing on the wire
	// Falling edge keeps the look away from the edge that launches the outputs
	always @(negedge i_clk) begin
		if (done)
			done_n++;
		gap++;
		if (wr_v) begin
			we = wr_q.size() ? wr_q.pop_front() : 'x;
			`CHK({wr_addr, wr_data}, we)
		end
		if (rd_v) begin
			re = rd_q.size() ? rd_q.pop_front() : 'x;
			`CHK(rd_data, re)
		end
		if (bus.scl && !scl_q) begin
			`CHK(gap >= 100, 1'b1)
			gap = 0;
		end
		scl_q = bus.scl;
	end

	// Watchdog well beyond the expected run
	initial begin
		repeat (100000) @(posedge i_clk);
		err_total++;
		report_and_stop();
	end

	// Main sequence
	initial begin
		void'($urandom(52035));
		{i_rst, addr_alt, rq_v, rq_rnw, rq_len, rq_reg, rq_data} = {1'b1, 30'h0};
		{loc_we, loc_addr, loc_data, touch, scl_q, gap} = {1'b0, 16'h0, 8'h0, 1'b0, 1'b1, 1000};
		repeat (4) @(posedge i_clk);
		#1;
		i_rst = 1'b0;
		// Fill the queue during boot, then offer one more that must be refused
		for (int i = 0; i < 8; i++)
			push(1'b0, 3'h0, 16'h8140 + 16'(i), 8'($urandom));
		`CHK(rq_rdy, 1'b0)
		rq_reg = 16'h8150;
		@(posedge i_clk);
		#1;
		settle();
		`CHK(alt_o, 1'b0)
		push(1'b1, 3'h7, 16'h8140, 8'h00);
		settle();
		// Touch data ready raises the request line until the host clears the flag
		{loc_we, loc_addr, loc_data} = {1'b1, 16'h814e, 8'h05};
		@(posedge i_clk);
		#1;
		{loc_we, touch} = 2'b01;
		@(posedge i_clk);
		#1;
		touch = 1'b0;
		repeat (10) @(posedge i_clk);
		#1;
		`CHK({coord, int_req}, 2'b11)
		mem[16'h814e] = 8'h85;
		push(1'b1, 3'h0, 16'h814e, 8'h00);
		settle();
		push(1'b0, 3'h0, 16'h814e, 8'h00);
		settle();
		repeat (10) @(posedge i_clk);
		#1;
		`CHK({coord, int_req, nack}, 3'b000)
		// Reset again with the other address pair strapped
		{i_rst, addr_alt} = 2'b11;
		repeat (4) @(posedge i_clk);
		#1;
		{i_rst, issued, done_n} = {1'b0, 32'h0, 32'h0};
		for (int i = 0; i < 300 && !boot_done; i++)
			@(posedge i_clk);
		#1;
		`CHK({alt_o, boot_done}, 2'b11)
		push(1'b0, 3'h0, 16'h815f, 8'($urandom));
		push(1'b1, 3'h2, 16'h815f, 8'h00);
		settle();
		`CHK({nack, wr_q.size(), rd_q.size()}, 65'h0)
		`CHK(busy, 1'b0)
		report_and_stop();
	end
endmodule : touch_ctrl_i2c_register_port_tb
`default_nettype wire
